// ==== shared/pblt_pkg.sv ====
// Package for the lane bit error tester: register map, fields, pattern codes.
// Assumes a 32-bit APB bus and four lanes in one clock domain.
package pblt_pkg;
   localparam int            PBLT_LANES       = 4;
   localparam int            PBLT_DW          = 32;
   localparam int            PBLT_AW          = 8;
   localparam int            PBLT_CNT_W       = 32;
   // Register byte offsets
   localparam logic [7:0]    PBLT_OFS_CTRL    = 8'h00;
   localparam logic [7:0]    PBLT_OFS_CMD     = 8'h04;
   localparam logic [7:0]    PBLT_OFS_STAT    = 8'h08;
   localparam logic [7:0]    PBLT_OFS_LANECFG = 8'h0c;
   localparam logic [7:0]    PBLT_OFS_ERR0    = 8'h10;
   // Lane config field: 8 bits per lane
   localparam int            PBLT_CFG_STRIDE  = 8;
   localparam int            PBLT_CFG_PAT     = 0;
   localparam int            PBLT_CFG_LOOP    = 3;
   localparam int            PBLT_CFG_DUPLEX  = 4;
   localparam int            PBLT_CFG_SEL     = 6;
   localparam int            PBLT_CFG_EXCL    = 7;
   localparam logic [31:0]   PBLT_CFG_RESET   = 32'h00000000;
   // Command bits
   localparam int            PBLT_CMD_START   = 0;
   localparam int            PBLT_CMD_STOP    = 1;
   localparam int            PBLT_CMD_PHYRST  = 2;
   localparam int            PBLT_CMD_INJ     = 4;
   localparam int            PBLT_CMD_CLR     = 8;
   // Status field: 8 bits per lane
   localparam int            PBLT_ST_STRIDE   = 8;
   // Pattern codes
   localparam logic [2:0]    PBLT_PAT_P7      = 3'h0;
   localparam logic [2:0]    PBLT_PAT_P9      = 3'h1;
   localparam logic [2:0]    PBLT_PAT_P15     = 3'h2;
   localparam logic [2:0]    PBLT_PAT_P23     = 3'h3;
   localparam logic [2:0]    PBLT_PAT_P31     = 3'h4;
   // Duplex codes
   localparam logic [1:0]    PBLT_DUP_FULL    = 2'h0;
   localparam logic [1:0]    PBLT_DUP_RXONLY  = 2'h1;
   localparam logic [1:0]    PBLT_DUP_TXONLY  = 2'h2;
   localparam logic [1:0]    PBLT_DUP_SPLIT   = 2'h3;
   // Checker sync: matching bits needed before counting
   localparam int            PBLT_SYNC_BITS   = 32;
   localparam logic [5:0]    PBLT_SYNC_MAX    = 6'd32;
   localparam logic [30:0]   PBLT_SEED        = 31'h7fffffff;
endpackage : pblt_pkg

// ==== core/pblt_lane.sv ====
// One lane: serial pattern generator and self-synchronising checker.
// Assumes one bit per clock on tx and rx, on pclk.
`timescale 1ns/1ps
`default_nettype none
module pblt_lane
   import pblt_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  run,
   input  wire logic [2:0]            pattern,
   input  wire logic                  inject,
   input  wire logic                  clear,
   input  wire logic                  rx_bit,
   output logic                       tx_bit,
   output logic [PBLT_CNT_W-1:0]      err_count,
   output logic                       synced
);
   import pblt_pkg::*;

   logic [30:0] gen;
   logic [30:0] chk;
   logic [5:0]  sync_cnt;

   function automatic logic fb(input logic [30:0] s, input logic [2:0] p);
      case (p)
         PBLT_PAT_P9:  fb = s[8] ^ s[4];
         PBLT_PAT_P15: fb = s[14] ^ s[13];
         PBLT_PAT_P23: fb = s[22] ^ s[17];
         PBLT_PAT_P31: fb = s[30] ^ s[27];
         default:      fb = s[6] ^ s[5];
      endcase
   endfunction : fb

   logic gen_bit;
   logic exp_bit;
   logic mism;
   assign gen_bit = fb(gen, pattern);
   assign exp_bit = fb(chk, pattern);
   assign mism    = exp_bit ^ rx_bit;

   // Generator with one-bit corruption on inject
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gen      <= PBLT_SEED;
         tx_bit   <= 1'b0;
      end
      else if (run)
      begin
         gen      <= {gen[29:0], gen_bit};
         tx_bit   <= gen_bit ^ inject;
      end
      else
      begin
         gen      <= PBLT_SEED;
         tx_bit   <= 1'b0;
      end
   end

   // Checker loads received bits every running cycle and counts matching bits until aligned
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chk      <= '0;
         sync_cnt <= '0;
      end
      else if (!run)
      begin
         chk      <= '0;
         sync_cnt <= '0;
      end
      else
      begin
         chk <= {chk[29:0], rx_bit};
         if (sync_cnt != PBLT_SYNC_MAX)
            sync_cnt <= mism ? 6'd0 : sync_cnt + 6'd1;
      end
   end

   assign synced = (sync_cnt == PBLT_SYNC_MAX);

   // Saturating error counter, clear wins only when no error arrives
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_count <= '0;
      else if (run && synced && mism)
      begin
         if (clear)
            err_count <= {{(PBLT_CNT_W-1){1'b0}}, 1'b1};
         else if (err_count != {PBLT_CNT_W{1'b1}})
            err_count <= err_count + 1'b1;
      end
      else if (clear)
         err_count <= '0;
   end
endmodule : pblt_lane
`default_nettype wire

// ==== core/pblt_top.sv ====
// Four-lane pseudo-random bit error tester with an APB register slave.
// Assumes lane status inputs are synchronous to pclk or slowly changing.
//
// How it works
// - Pattern select 7/9/15/23/31 stages per lane, 7 after reset.
// - Four lanes per instance; 7, 9, 23, 31 are the configured patterns.
// - Each lane has its own generator and checker.
// - Running checkers count mismatches into a readable error counter.
// - Per-lane clear zeroes the count, or sets it to one if an error arrives in the same cycle.
// - Inject during a run flips one transmitted bit.
// - Inject ignored for a pattern outside the configured set.
// - Start enables selected lanes with their chosen pattern.
// - Stop halts every running lane in one cycle.
// - Near-end loopback routes tx to rx; refused on half duplex.
// - Separate tx and rx path ready flags per lane.
// - Tx PLL, rx PLL and data lock flags per lane.
// - Half-duplex lanes report inapplicable side status as zero.
// - Physical reset goes to selected lanes; ignored while testing.
// - Lanes that cannot start are flagged; others still start.
// - Express-link and unused lanes are excluded from testing.
`timescale 1ns/1ps
`default_nettype none
module pblt_top
   import pblt_pkg::*;
(
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [pblt_pkg::PBLT_AW-1:0]      paddr,
   input  wire logic [pblt_pkg::PBLT_DW-1:0]      pwdata,
   input  wire logic [3:0]                        pstrb,
   output logic      [pblt_pkg::PBLT_DW-1:0]      prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   rx_serial,
   output logic      [pblt_pkg::PBLT_LANES-1:0]   tx_serial,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   tx_path_ready,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   rx_path_ready,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   tx_pll_lock,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   rx_pll_lock,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   data_locked,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   express_lane,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0]   lane_unused,
   output logic      [pblt_pkg::PBLT_LANES-1:0]   phy_reset,
   output logic      [pblt_pkg::PBLT_LANES-1:0]   near_end_loopback
);
   import pblt_pkg::*;

   logic [PBLT_DW-1:0]    lane_cfg;
   logic [PBLT_LANES-1:0] running;
   logic [PBLT_LANES-1:0] start_fail;
   logic [PBLT_LANES-1:0] inject;
   logic [PBLT_LANES-1:0] clear;
   logic [PBLT_LANES-1:0] synced;
   logic [PBLT_LANES-1:0] rx_mux;
   logic [PBLT_LANES-1:0] tx_int;
   logic [PBLT_LANES-1:0] can_run;
   logic [PBLT_LANES-1:0] sel_lane;
   logic [PBLT_LANES-1:0] cfg_pat;
   logic [PBLT_LANES-1:0] half_dup;
   logic [PBLT_LANES-1:0] st_txr;
   logic [PBLT_LANES-1:0] st_rxr;
   logic [PBLT_LANES-1:0] st_txp;
   logic [PBLT_LANES-1:0] st_rxp;
   logic [PBLT_LANES-1:0] st_dl;
   logic [PBLT_CNT_W-1:0] err_cnt [PBLT_LANES];
   logic                  wr_acc;
   logic                  rd_acc;
   logic                  cmd_wr;
   logic                  start_cmd;
   logic                  stop_cmd;
   logic                  phyrst_cmd;
   logic                  addr_ok;
   logic [PBLT_DW-1:0]    next_prdata;

   // APB access decode, zero wait states
   assign pready    = 1'b1;
   assign wr_acc    = psel && penable && pwrite;
   assign rd_acc    = psel && !penable && !pwrite;
   assign cmd_wr    = wr_acc && (paddr == PBLT_OFS_CMD);
   assign start_cmd = cmd_wr && pwdata[PBLT_CMD_START];
   assign stop_cmd  = cmd_wr && pwdata[PBLT_CMD_STOP];
   assign phyrst_cmd = cmd_wr && pwdata[PBLT_CMD_PHYRST];

   always_comb
   begin
      addr_ok = 1'b0;
      if (paddr == PBLT_OFS_CTRL)
         addr_ok = 1'b1;
      else if (paddr == PBLT_OFS_CMD)
         addr_ok = 1'b1;
      else if (paddr == PBLT_OFS_STAT)
         addr_ok = 1'b1;
      else if (paddr == PBLT_OFS_LANECFG)
         addr_ok = 1'b1;
      else if (paddr >= PBLT_OFS_ERR0 && paddr < PBLT_OFS_ERR0 + 8'h10 && paddr[1:0] == 2'b00)
         addr_ok = 1'b1;
   end

   assign pslverr = psel && penable && !addr_ok;

   // Lane config register with byte enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lane_cfg <= PBLT_CFG_RESET;
      else if (wr_acc && paddr == PBLT_OFS_LANECFG)
      begin
         for (int b = 0; b < 4; b++)
            if (pstrb[b])
               lane_cfg[8*b +: 8] <= pwdata[8*b +: 8];
      end
   end

   // Per-lane decode, run control and status
   genvar g;
   generate
      for (g = 0; g < PBLT_LANES; g++)
      begin : g_lane
         logic [2:0] pat;
         logic [1:0] dup;
         assign pat          = lane_cfg[g*PBLT_CFG_STRIDE+PBLT_CFG_PAT +: 3];
         assign dup          = lane_cfg[g*PBLT_CFG_STRIDE+PBLT_CFG_DUPLEX +: 2];
         assign sel_lane[g]  = lane_cfg[g*PBLT_CFG_STRIDE+PBLT_CFG_SEL];
         assign half_dup[g]  = (dup != PBLT_DUP_FULL);
         assign cfg_pat[g]   = (pat == PBLT_PAT_P7) || (pat == PBLT_PAT_P9) ||
                               (pat == PBLT_PAT_P23) || (pat == PBLT_PAT_P31);
         assign can_run[g]   = !express_lane[g] && !lane_unused[g] &&
                               !lane_cfg[g*PBLT_CFG_STRIDE+PBLT_CFG_EXCL] && (pat <= PBLT_PAT_P31);
         assign near_end_loopback[g] = lane_cfg[g*PBLT_CFG_STRIDE+PBLT_CFG_LOOP] && !half_dup[g];
         assign rx_mux[g]    = near_end_loopback[g] ? tx_int[g] : rx_serial[g];
         assign inject[g]    = cmd_wr && pwdata[PBLT_CMD_INJ+g] && running[g] && cfg_pat[g];
         assign clear[g]     = cmd_wr && pwdata[PBLT_CMD_CLR+g];
         assign st_txr[g]    = tx_path_ready[g] && dup != PBLT_DUP_RXONLY;
         assign st_rxr[g]    = rx_path_ready[g] && dup != PBLT_DUP_TXONLY;
         assign st_txp[g]    = tx_pll_lock[g] && dup != PBLT_DUP_RXONLY;
         assign st_rxp[g]    = rx_pll_lock[g] && dup != PBLT_DUP_TXONLY;
         assign st_dl[g]     = data_locked[g] && dup != PBLT_DUP_TXONLY;

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               running[g]    <= 1'b0;
               start_fail[g] <= 1'b0;
            end
            else if (stop_cmd)
               running[g] <= 1'b0;
            else if (start_cmd && sel_lane[g])
            begin
               running[g]    <= can_run[g];
               start_fail[g] <= !can_run[g];
            end
            else if (!can_run[g])
               running[g] <= 1'b0;
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               phy_reset[g] <= 1'b0;
            else
               phy_reset[g] <= phyrst_cmd && sel_lane[g] && (running == '0);
         end

         pblt_lane u_lane
         (
            .pclk      (pclk),
            .presetn   (presetn),
            .run       (running[g]),
            .pattern   (pat),
            .inject    (inject[g]),
            .clear     (clear[g]),
            .rx_bit    (rx_mux[g]),
            .tx_bit    (tx_int[g]),
            .err_count (err_cnt[g]),
            .synced    (synced[g])
         );

         assign tx_serial[g] = tx_int[g];
      end
   endgenerate

   // Read mux, data taken at setup and held through access
   always_comb
   begin
      next_prdata = '0;
      if (paddr == PBLT_OFS_CTRL)
         next_prdata = {{(PBLT_DW-2*PBLT_LANES){1'b0}}, start_fail, running};
      else if (paddr == PBLT_OFS_STAT)
      begin
         for (int i = 0; i < PBLT_LANES; i++)
            next_prdata[i*PBLT_ST_STRIDE +: PBLT_ST_STRIDE] =
               {1'b0, st_txr[i], cfg_pat[i], synced[i], st_dl[i], st_rxp[i], st_txp[i], st_rxr[i]};
      end
      else if (paddr == PBLT_OFS_LANECFG)
         next_prdata = lane_cfg;
      else if (paddr >= PBLT_OFS_ERR0 && paddr < PBLT_OFS_ERR0 + 8'h10)
         next_prdata = err_cnt[paddr[3:2]];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (rd_acc)
         prdata <= next_prdata;
   end
endmodule : pblt_top
`default_nettype wire

// ==== verification/pblt_far_lane.sv ====
// Far-end lane model: echoes each tx bit back to rx.
// Assumes one bit per pclk; flip corrupts the cable path.
`timescale 1ns/1ps
`default_nettype none
module pblt_far_lane
   import pblt_pkg::*;
(
   input  wire logic [pblt_pkg::PBLT_LANES-1:0] tx_serial,
   input  wire logic                            pclk,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0] loop_en,
   input  wire logic [pblt_pkg::PBLT_LANES-1:0] flip,
   output logic      [pblt_pkg::PBLT_LANES-1:0] rx_serial
);
   logic [PBLT_LANES-1:0] cable;
   always_ff @(posedge pclk)
      cable <= tx_serial ^ flip;
   assign rx_serial = (loop_en & tx_serial) | (~loop_en & cable);
endmodule : pblt_far_lane
`default_nettype wire

// ==== verification/pblt_chk.sv ====
// Checker on the tester ports: bus replies, phy reset, loopback.
// Assumes a bind to pblt_top; shadows lane config from bus writes.
`timescale 1ns/1ps
`default_nettype none
module pblt_chk
   import pblt_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  phy_reset,
   input wire logic [3:0]  near_end_loopback
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] cfg;
   logic [3:0]  sel;
   logic [3:0]  loop;
   logic        wr;
   assign wr = psel & penable & pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cfg <= PBLT_CFG_RESET;
      else if (wr && paddr == PBLT_OFS_LANECFG)
         for (int b = 0; b < 4; b++)
            if (pstrb[b])
               cfg[8*b +: 8] <= pwdata[8*b +: 8];
   always_comb
      for (int i = 0; i < 4; i++)
      begin
         sel[i] = cfg[8*i+6];
         loop[i] = cfg[8*i+3] && cfg[8*i+4 +: 2] == 2'h0;
      end
   a_pready_high: assert property (pready) else $error("pready low");
   a_unmapped_err: assert property (psel && penable && paddr >= 8'h20 |-> pslverr)
      else $error("no error on unmapped");
   a_mapped_ok: assert property (psel && penable && paddr < 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped");
   a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
   a_phy_pulse: assert property (phy_reset != 4'h0 |=> phy_reset == 4'h0)
      else $error("phy reset too long");
   a_phy_cause: assert property (phy_reset != 4'h0 |-> $past(wr && paddr == PBLT_OFS_CMD && pwdata[2]))
      else $error("phy reset uncaused");
   a_phy_lanes: assert property (phy_reset != 4'h0 |-> phy_reset == sel)
      else $error("phy reset lanes");
   a_loop_route: assert property (near_end_loopback == loop)
      else $error("loopback setting");
   c_phy: cover property (phy_reset != 4'h0);
   c_loop: cover property (near_end_loopback != 4'h0);
   c_inject: cover property (wr && paddr == PBLT_OFS_CMD && pwdata[7:4] != 4'h0);
endmodule : pblt_chk
`default_nettype wire

// ==== verification/tb_top.sv ====
// Bench for the lane tester: APB tasks and directed tests.
// Assumes the far-lane model returns tx to rx on every lane.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pblt_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, se;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, tx, rx, txr, rxr, txp, rxp, dl, expr, unu, phy, loop, flip;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cyc = 0;
   always #4 pclk = ~pclk;
   pblt_top i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .rx_serial(rx), .tx_serial(tx), .tx_path_ready(txr), .rx_path_ready(rxr), .tx_pll_lock(txp),
      .rx_pll_lock(rxp), .data_locked(dl), .express_lane(expr), .lane_unused(unu), .phy_reset(phy),
      .near_end_loopback(loop));
   pblt_far_lane i_far(.pclk, .tx_serial(tx), .loop_en(loop), .flip, .rx_serial(rx));
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         $display("ERROR %0t timeout", $time);
         give_verdict();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, m);
   endtask : rdc
   task automatic phy_try(input logic [3:0] exp);
      logic [3:0] acc;
      acc = 4'h0;
      apb(1'b1, PBLT_OFS_CMD, 32'h4);
      repeat (3)
      begin
         @(posedge pclk);
         acc = acc | phy;
      end
      chk({28'h0, acc}, {28'h0, exp}, "phy reset lanes");
   endtask : phy_try
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, expr, unu, flip} = '0;
      {pstrb, txr, rxr, txp, rxp, dl} = '1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(PBLT_OFS_LANECFG, PBLT_CFG_RESET, "config reset");
      rdc(PBLT_OFS_CTRL, 32'h0, "idle control");
      apb(1'b1, PBLT_OFS_LANECFG, 32'h48685848);
      rxr <= 4'he;
      dl <= 4'h7;
      apb(1'b0, PBLT_OFS_STAT, 32'h0);
      chk(rd & 32'h4f4f4f4f, 32'h47420d4e, "lane status");
      chk({28'h0, loop}, 32'h9, "loopback");
      {rxr, dl} <= 8'hff;
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b1, PBLT_OFS_LANECFG, 32'h48 | k);
         apb(1'b1, PBLT_OFS_CMD, 32'h1);
         rdc(PBLT_OFS_CTRL, k < 5 ? 32'h1 : 32'h10, "start by pattern");
         apb(1'b1, PBLT_OFS_CMD, 32'h3);
         rdc(PBLT_OFS_CTRL, k < 5 ? 32'h0 : 32'h10, "stop wins");
      end
      expr <= 4'h8;
      unu <= 4'h4;
      apb(1'b1, PBLT_OFS_LANECFG, 32'h43444240);
      apb(1'b1, PBLT_OFS_CMD, 32'h1);
      rdc(PBLT_OFS_CTRL, 32'hc3, "partial start");
      repeat (200) @(posedge pclk);
      apb(1'b0, PBLT_OFS_STAT, 32'h0);
      chk(rd & 32'h1010, 32'h1010, "checker synced");
      rdc(PBLT_OFS_ERR0, 32'h0, "no spurious errors");
      apb(1'b1, PBLT_OFS_CMD, 32'h30);
      repeat (50) @(posedge pclk);
      apb(1'b0, PBLT_OFS_ERR0, 32'h0);
      chk({31'h0, rd != 32'h0}, 32'h1, "inject counted");
      rdc(PBLT_OFS_ERR0 + 8'h4, 32'h0, "inject on unconfigured pattern");
      apb(1'b1, PBLT_OFS_CMD, 32'h100);
      rdc(PBLT_OFS_ERR0, 32'h0, "clear while running");
      flip <= 4'h1;
      @(posedge pclk);
      flip <= 4'h0;
      repeat (50) @(posedge pclk);
      apb(1'b0, PBLT_OFS_ERR0, 32'h0);
      chk({31'h0, rd != 32'h0}, 32'h1, "line error counted");
      phy_try(4'h0);
      apb(1'b1, PBLT_OFS_CMD, 32'h102);
      rdc(PBLT_OFS_CTRL, 32'hc0, "stop all");
      flip <= 4'h1;
      @(posedge pclk);
      flip <= 4'h0;
      repeat (50) @(posedge pclk);
      rdc(PBLT_OFS_ERR0, 32'h0, "no count after stop");
      {expr, unu} <= 8'h00;
      phy_try(4'hf);
      rdc(8'h20, 32'h0, "unmapped read");
      chk({31'h0, se}, 32'h1, "unmapped error");
      give_verdict();
   end
endmodule : tb_top
bind pblt_top pblt_chk i_chk(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .pslverr, .phy_reset, .near_end_loopback);
`default_nettype wire
